// File: core/tsw_pkg.sv
// Constants, register map and types for the touch switch output logic
package tsw_pkg;
    // ==========================================================
    // Register bus
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_TMO      = 8'h04;
    localparam logic [7:0]  ADDR_STAT     = 8'h08;
    // ==========================================================
    // Control register fields
    localparam int          CTRL_VAR_LSB  = 0;
    localparam int          CTRL_LEDOFF   = 2;
    localparam int          CTRL_LOWPWR   = 3;
    localparam int          CTRL_TMO_LSB  = 4;
    localparam logic [5:0]  CTRL_RST      = 6'h00;
    localparam logic [31:0] TMO_RST       = 32'h0000_0400;
    // ==========================================================
    // Status register fields
    localparam int          STAT_SW       = 0;
    localparam int          STAT_SEL_LSB  = 1;
    localparam int          STAT_LEDPIN   = 6;
    localparam int          STAT_TCH_LSB  = 7;
    // ==========================================================
    // Timing
    localparam int          NPAD          = 5;
    localparam longint      CLK_HZ        = 40_000_000;
    localparam longint      CLK_NS        = 25;
    localparam longint      TMO_SHORT_S   = 900;
    localparam longint      TMO_LONG_S    = 3600;
    localparam logic [39:0] TMO_SHORT_CYC = 40'(TMO_SHORT_S * CLK_HZ);
    localparam logic [39:0] TMO_LONG_CYC  = 40'(TMO_LONG_S * CLK_HZ);
    localparam longint      LP_SAMPLE_NS  = 1000;
    localparam logic [7:0]  LP_SAMPLE_CYC = 8'((LP_SAMPLE_NS + CLK_NS - 1) / CLK_NS);
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        TSW_MOMENTARY = 2'b00,
        TSW_TOGGLE    = 2'b01,
        TSW_FIVE      = 2'b10
    } tsw_variant_e;
    typedef enum logic [1:0] {
        TSW_TMO_NONE   = 2'b00,
        TSW_TMO_CUSTOM = 2'b01,
        TSW_TMO_HIGH   = 2'b10,
        TSW_TMO_OUT    = 2'b11
    } tsw_tmo_e;
    typedef enum logic {
        TSW_SEL_IDLE = 1'b0,
        TSW_SEL_LOCK = 1'b1
    } tsw_sel_e;
endpackage

// File: core/tsw_sel_if.sv
// Pad selection carrier between the top and the pad arbiter
interface tsw_sel_if;
    logic [4:0] touch;
    logic       sample;
    logic [4:0] sel;
    modport owner (output touch, output sample, input sel);
    modport arb   (input touch, input sample, output sel);
endinterface

// File: core/tsw_pad_select.sv
// Five-pad arbiter: reports at most one touched pad
module tsw_pad_select (
    input wire logic i_clk,
    input wire logic i_rst,
    tsw_sel_if.arb   bus
);
    tsw_pkg::tsw_sel_e state;
    logic [4:0]        sel;

    // ==========================================================
    // Lowest pad wins; it holds until released so a neighbour cannot steal it
    function automatic logic [4:0] lowest(input logic [4:0] v);
        return v & (~v + 5'h01);
    endfunction

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= tsw_pkg::TSW_SEL_IDLE;
            sel   <= 5'h00;
        end else if (bus.sample) begin
            unique case (state)
                tsw_pkg::TSW_SEL_IDLE: begin
                    if (|bus.touch) begin
                        sel   <= lowest(bus.touch);
                        state <= tsw_pkg::TSW_SEL_LOCK;
                    end
                end
                tsw_pkg::TSW_SEL_LOCK: begin
                    if ((bus.touch & sel) == 5'h00) begin
                        sel   <= 5'h00;
                        state <= tsw_pkg::TSW_SEL_IDLE;
                    end
                end
            endcase
        end
    end
    assign bus.sel = sel;

    // ==========================================================
    property p_onehot;
        @(posedge i_clk) disable iff (i_rst) $onehot0(sel);
    endproperty
    a_onehot: assert property (p_onehot) else $error("More than one pad reported");
    property p_lock;
        @(posedge i_clk) disable iff (i_rst)
            (sel != 5'h00 && bus.sample && ((bus.touch & sel) != 5'h00)) |=> $stable(sel);
    endproperty
    a_lock: assert property (p_lock) else $error("Held pad lost while touched");
endmodule // tsw_pad_select

// File: core/tsw_top.sv
// Touch switch output logic: momentary, toggle and five-pad variants
// ==========================================================
// Functional notes
// - Toggle: touch while off turns output on, next touch turns it off.
// - Momentary: output high exactly while touch is detected.
// - Indicator LED mirrors the switch output in toggle and momentary.
// - LED control disconnected: stop driving LED, external terminal takes over.
// - Momentary has fast and low-power sampling, fast by default.
// - Toggle default has no timeout; output stays on until touched.
// - Timeout enabled: toggle output drops after configured delay since on.
// - Timeout tied high: output drops about 15 minutes after on.
// - Timeout tied to output: output drops about one hour after on.
// - Toggle and momentary outputs are active high.
// - Five-pad variant: five sense inputs, LED of touched pad lights.
// - Five-pad variant reports at most one touched pad at a time.
// - Five-pad outputs are active low while their pad is touched.
module tsw_top #(
    parameter logic [39:0] P_TMO_SHORT_CYC = tsw_pkg::TMO_SHORT_CYC,
    parameter logic [39:0] P_TMO_LONG_CYC  = tsw_pkg::TMO_LONG_CYC
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    input  wire logic [4:0]  I_TOUCH,
    input  wire logic        I_LED,
    output logic             O_LED,
    output logic             O_LED_OE,
    output logic             O_SW_OUT,
    output logic [4:0]       O_KEY_N,
    output logic [4:0]       O_PAD_LED,
    input  wire logic [7:0]  I_ADDR,
    input  wire logic [31:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic [31:0]      O_RDATA
);
    logic [5:0]               ctrl;
    logic [31:0]              tmo_reg;
    logic [4:0]               touch_sync1;
    logic [4:0]               touch_sync2;
    logic                     led_sync1;
    logic                     led_sync2;
    logic [7:0]               lp_cnt;
    logic                     smp_stb;
    logic [4:0]               touch_smp;
    logic                     touch_prev;
    logic                     rise;
    logic                     sw;
    logic                     next_sw;
    logic                     led_drv;
    logic                     led_oe;
    logic [39:0]              tmo_cnt;
    logic [39:0]              tmo_limit;
    logic                     tmo_hit;
    logic [4:0]               key_n;
    logic [4:0]               pad_led;
    logic [31:0]              rdata;
    tsw_pkg::tsw_variant_e    variant;
    tsw_pkg::tsw_tmo_e        tmo_mode;
    logic                     ctl_led_off;
    logic                     ctl_lowpwr;
    tsw_sel_if                sel_bus ();

    assign variant     = tsw_pkg::tsw_variant_e'(ctrl[tsw_pkg::CTRL_VAR_LSB +: 2]);
    assign tmo_mode    = tsw_pkg::tsw_tmo_e'(ctrl[tsw_pkg::CTRL_TMO_LSB +: 2]);
    assign ctl_led_off = ctrl[tsw_pkg::CTRL_LEDOFF];
    assign ctl_lowpwr  = ctrl[tsw_pkg::CTRL_LOWPWR];

    // ==========================================================
    // Register writes
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ctrl    <= tsw_pkg::CTRL_RST;
            tmo_reg <= tsw_pkg::TMO_RST;
        end else if (I_WR) begin
            if (I_ADDR == tsw_pkg::ADDR_CTRL) begin
                ctrl <= I_WDATA[5:0];
            end
            if (I_ADDR == tsw_pkg::ADDR_TMO) begin
                tmo_reg <= I_WDATA;
            end
        end
    end

    // ==========================================================
    // Register reads: data stand one cycle, unmapped reads zero
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            rdata <= 32'h0000_0000;
        end else if (I_RD) begin
            unique case (I_ADDR)
                tsw_pkg::ADDR_CTRL: rdata <= {26'h0000000, ctrl};
                tsw_pkg::ADDR_TMO:  rdata <= tmo_reg;
                tsw_pkg::ADDR_STAT: rdata <= {20'h00000, touch_smp, led_sync2, sel_bus.sel, sw};
                default:            rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end
    assign O_RDATA = rdata;

    // ==========================================================
    // Pin synchronisers
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            touch_sync1 <= 5'h00;
            touch_sync2 <= 5'h00;
            led_sync1   <= 1'b0;
            led_sync2   <= 1'b0;
        end else begin
            touch_sync1 <= I_TOUCH;
            touch_sync2 <= touch_sync1;
            led_sync1   <= I_LED;
            led_sync2   <= led_sync1;
        end
    end

    // ==========================================================
    // Sampling rate: low power trades response time for fewer samples
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            lp_cnt <= 8'h00;
        end else if (!ctl_lowpwr || lp_cnt == tsw_pkg::LP_SAMPLE_CYC - 8'h01) begin
            lp_cnt <= 8'h00;
        end else begin
            lp_cnt <= lp_cnt + 8'h01;
        end
    end
    assign smp_stb = !ctl_lowpwr || lp_cnt == 8'h00;

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            touch_smp  <= 5'h00;
            touch_prev <= 1'b0;
        end else begin
            if (smp_stb) begin
                touch_smp <= touch_sync2;
            end
            touch_prev <= touch_smp[0];
        end
    end
    assign rise = touch_smp[0] && !touch_prev;

    // ==========================================================
    // Timeout
    always_comb begin
        unique case (tmo_mode)
            tsw_pkg::TSW_TMO_NONE:   tmo_limit = 40'hff_ffff_ffff;
            tsw_pkg::TSW_TMO_CUSTOM: tmo_limit = {8'h00, tmo_reg};
            tsw_pkg::TSW_TMO_HIGH:   tmo_limit = P_TMO_SHORT_CYC;
            tsw_pkg::TSW_TMO_OUT:    tmo_limit = P_TMO_LONG_CYC;
        endcase
    end
    assign tmo_hit = tmo_mode != tsw_pkg::TSW_TMO_NONE && tmo_cnt >= tmo_limit;

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            tmo_cnt <= 40'h00_0000_0000;
        end else if (!sw || tmo_mode == tsw_pkg::TSW_TMO_NONE) begin
            tmo_cnt <= 40'h00_0000_0000;
        end else if (!tmo_hit) begin
            tmo_cnt <= tmo_cnt + 40'h00_0000_0001;
        end
    end

    // ==========================================================
    // Switch state
    always_comb begin
        unique case (variant)
            tsw_pkg::TSW_TOGGLE: begin
                if (rise) begin
                    next_sw = !sw;
                end else if (sw && tmo_hit) begin
                    next_sw = 1'b0;
                end else begin
                    next_sw = sw;
                end
            end
            tsw_pkg::TSW_FIVE: next_sw = 1'b0;
            default:           next_sw = touch_smp[0];
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            sw      <= 1'b0;
            led_drv <= 1'b0;
            led_oe  <= 1'b0;
        end else begin
            sw      <= next_sw;
            led_drv <= next_sw;
            led_oe  <= !ctl_led_off && variant != tsw_pkg::TSW_FIVE;
        end
    end
    assign O_SW_OUT = sw;
    assign O_LED    = led_drv;
    assign O_LED_OE = led_oe;

    // ==========================================================
    // Five-pad variant
    assign sel_bus.touch  = touch_smp;
    assign sel_bus.sample = smp_stb;

    tsw_pad_select u_sel (
        .i_clk (I_CLK),
        .i_rst (I_RST),
        .bus   (sel_bus.arb)
    );

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            key_n   <= 5'h1f;
            pad_led <= 5'h00;
        end else if (variant == tsw_pkg::TSW_FIVE) begin
            key_n   <= ~sel_bus.sel;
            pad_led <= sel_bus.sel;
        end else begin
            key_n   <= 5'h1f;
            pad_led <= 5'h00;
        end
    end
    assign O_KEY_N   = key_n;
    assign O_PAD_LED = pad_led;

    // ==========================================================
    // Assertions
    property p_tog_on;
        @(posedge I_CLK) disable iff (I_RST)
            (variant == tsw_pkg::TSW_TOGGLE && rise && !sw) |=> O_SW_OUT;
    endproperty
    a_tog_on: assert property (p_tog_on) else $error("Toggle did not turn on");
    property p_tog_off;
        @(posedge I_CLK) disable iff (I_RST)
            (variant == tsw_pkg::TSW_TOGGLE && rise && sw) |=> !O_SW_OUT;
    endproperty
    a_tog_off: assert property (p_tog_off) else $error("Toggle did not turn off");
    property p_mom;
        @(posedge I_CLK) disable iff (I_RST)
            (variant == tsw_pkg::TSW_MOMENTARY) |=> O_SW_OUT == $past(touch_smp[0]);
    endproperty
    a_mom: assert property (p_mom) else $error("Momentary output not following touch");
    property p_led;
        @(posedge I_CLK) disable iff (I_RST) O_LED == O_SW_OUT;
    endproperty
    a_led: assert property (p_led) else $error("LED does not mirror output");
    property p_led_off;
        @(posedge I_CLK) disable iff (I_RST) ctl_led_off |=> !O_LED_OE;
    endproperty
    a_led_off: assert property (p_led_off) else $error("LED driven while disconnected");
    property p_lp;
        @(posedge I_CLK) disable iff (I_RST)
            (ctl_lowpwr && $past(ctl_lowpwr) && smp_stb) |=> !smp_stb;
    endproperty
    a_lp: assert property (p_lp) else $error("Low-power sampling too frequent");
    property p_fast;
        @(posedge I_CLK) disable iff (I_RST) !ctl_lowpwr |-> smp_stb;
    endproperty
    a_fast: assert property (p_fast) else $error("Fast mode skipped a sample");
    property p_hold;
        @(posedge I_CLK) disable iff (I_RST)
            (variant == tsw_pkg::TSW_TOGGLE && tmo_mode == tsw_pkg::TSW_TMO_NONE && sw && !rise)
            |=> O_SW_OUT;
    endproperty
    a_hold: assert property (p_hold) else $error("Output dropped without touch");
    property p_tmo;
        @(posedge I_CLK) disable iff (I_RST)
            (variant == tsw_pkg::TSW_TOGGLE && sw && tmo_hit && !rise) |=> !O_SW_OUT;
    endproperty
    a_tmo: assert property (p_tmo) else $error("Timeout did not drop output");
    property p_short;
        @(posedge I_CLK) disable iff (I_RST)
            (tmo_mode == tsw_pkg::TSW_TMO_HIGH && sw && tmo_cnt < P_TMO_SHORT_CYC) |-> !tmo_hit;
    endproperty
    a_short: assert property (p_short) else $error("Short timeout fired early");
    property p_long;
        @(posedge I_CLK) disable iff (I_RST)
            (tmo_mode == tsw_pkg::TSW_TMO_OUT && sw && tmo_cnt == P_TMO_LONG_CYC) |-> tmo_hit;
    endproperty
    a_long: assert property (p_long) else $error("Long timeout did not fire");
    property p_pad;
        @(posedge I_CLK) disable iff (I_RST)
            (variant == tsw_pkg::TSW_FIVE) |=> O_PAD_LED == $past(sel_bus.sel);
    endproperty
    a_pad: assert property (p_pad) else $error("Pad LED not on selected pad");
    property p_keyn;
        @(posedge I_CLK) disable iff (I_RST) O_KEY_N == ~O_PAD_LED;
    endproperty
    a_keyn: assert property (p_keyn) else $error("Pad output not active low");
    property p_once;
        @(posedge I_CLK) disable iff (I_RST)
            (variant == tsw_pkg::TSW_TOGGLE && touch_smp[0] && touch_prev && !tmo_hit)
            |=> $stable(O_SW_OUT);
    endproperty
    a_once: assert property (p_once) else $error("Sustained touch toggled again");

    c_toggle: cover property (@(posedge I_CLK) disable iff (I_RST)
        variant == tsw_pkg::TSW_TOGGLE && rise && !sw ##1 O_SW_OUT);
    c_timeout: cover property (@(posedge I_CLK) disable iff (I_RST)
        sw && tmo_hit && !rise ##1 !O_SW_OUT);
    c_five: cover property (@(posedge I_CLK) disable iff (I_RST)
        variant == tsw_pkg::TSW_FIVE && O_KEY_N != 5'h1f);
    c_lowpwr: cover property (@(posedge I_CLK) disable iff (I_RST)
        ctl_lowpwr && smp_stb && touch_smp[0]);
endmodule // tsw_top

// File: verification/tsw_host_model.sv
// Host side model: LED pin wiring and a counter of switch turn-on events
module tsw_host_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_led,
    input  wire logic       i_led_oe,
    input  wire logic       i_sw_out,
    input  wire logic       i_ext_drv,
    output logic            o_led_pin,
    output logic [7:0]      o_on_count
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sw_d;
    // ==========================================================
    // LED pin: block drives it, otherwise the outside source does
    assign o_led_pin = i_led_oe ? i_led : i_ext_drv;
    // ==========================================================
    // Turn-on counter; a held touch must add only one
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sw_d       <= 1'b0;
            o_on_count <= 8'h00;
        end else begin
            sw_d <= i_sw_out;
            if (i_sw_out && !sw_d) begin
                o_on_count <= o_on_count + 8'h01;
            end
        end
    end
endmodule // tsw_host_model

// File: verification/tb.sv
// Self-checking bench for the touch switch output logic
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    $display("unexpected %s expected %h seen %h", nm, e, g); n_errors++; end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0, rst = 1'b1, ext_drv = 1'b0, led_pin;
    logic [4:0]  touch = 5'h00, key_n, pad_led;
    logic        led, led_oe, sw_out, wr = 1'b0, rd = 1'b0;
    logic [7:0]  addr = 8'h00, on_cnt;
    logic [31:0] wdata = 32'h0, rdata, d;
    int          n_errors = 0, compares = 0, cyc = 0;
    always #12.5 clk = ~clk;
    tsw_top #(.P_TMO_SHORT_CYC(40'h14), .P_TMO_LONG_CYC(40'h32)) u_tsw_top (
        .I_CLK(clk), .I_RST(rst), .I_TOUCH(touch), .I_LED(led_pin), .O_LED(led),
        .O_LED_OE(led_oe), .O_SW_OUT(sw_out), .O_KEY_N(key_n), .O_PAD_LED(pad_led),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata));
    tsw_host_model u_tsw_host_model (.i_clk(clk), .i_rst(rst), .i_led(led),
        .i_led_oe(led_oe), .i_sw_out(sw_out), .i_ext_drv(ext_drv),
        .o_led_pin(led_pin), .o_on_count(on_cnt));
    // ==========================================================
    // Bus and stimulus tasks
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a; wdata <= v; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic press(input logic [4:0] v, input int n);
        @(posedge clk);
        touch <= v;
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Limits are the reduced bench values, so runs stay short
    task automatic tmo_run(input logic [1:0] m, input int lim);
        int n, w;
        n = 0;
        w = 0;
        bus_wr(8'h00, {26'h0, m, 4'h1});
        press(5'h01, 2);
        press(5'h00, 0);
        while (sw_out !== 1'b1 && w < 20) begin @(posedge clk); #1; w++; end
        while (sw_out === 1'b1 && n < 1000) begin @(posedge clk); #1; n++; end
        `CHK("tmo_len", 1'b1, (n >= lim && n <= lim + 3))
    endtask
    task automatic complete_run;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Hang guard: the whole sequence needs under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            complete_run();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] c0;
        logic [4:0] tv;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK("rst_sw", 1'b0, sw_out)
        `CHK("rst_key", 5'h1f, key_n)
        @(posedge clk);
        @(posedge clk);
        #1;
        `CHK("led_oe", 1'b1, led_oe)
        bus_rd(8'h00, d); `CHK("ctrl_rst", 32'h0, d)
        bus_rd(8'h04, d); `CHK("tmo_rst", 32'h400, d)
        // Read data stand for one cycle only, then the bus returns to zero
        @(posedge clk); #1;
        `CHK("rd_idle", 32'h0, rdata)
        bus_rd(8'h0c, d); `CHK("unmapped", 32'h0, d)
        bus_wr(8'h08, 32'hffff_ffff);
        bus_wr(8'h00, 32'hffff_ffc0);
        bus_rd(8'h00, d); `CHK("ctrl_mask", 32'h0, d)
        // Momentary, fast: output follows touch four edges later
        press(5'h01, 3); `CHK("mom_early", 1'b0, sw_out)
        press(5'h01, 0);
        @(posedge clk); #1;
        `CHK("mom_on", 1'b1, sw_out)
        `CHK("mom_led", 1'b1, led)
        press(5'h00, 4); `CHK("mom_off", 1'b0, sw_out)
        `CHK("mom_led0", 1'b0, led)
        // Low-power sampling adds at most 39 cycles
        bus_wr(8'h00, 32'h08);
        press(5'h01, 44); `CHK("lp_on", 1'b1, sw_out)
        press(5'h00, 44); `CHK("lp_off", 1'b0, sw_out)
        // LED disconnected: outside source owns the pin
        bus_wr(8'h00, 32'h04);
        ext_drv <= 1'b1;
        press(5'h01, 6); `CHK("dis_oe", 1'b0, led_oe)
        `CHK("dis_sw", 1'b1, sw_out)
        bus_rd(8'h08, d); `CHK("dis_pin", 1'b1, d[6])
        @(posedge clk);
        ext_drv <= 1'b0;
        press(5'h00, 6);
        // Toggle: held touch flips once, stays on without timeout
        bus_wr(8'h00, 32'h01);
        c0 = on_cnt;
        press(5'h01, 30); `CHK("tgl_on", 1'b1, sw_out)
        `CHK("tgl_led", 1'b1, led)
        press(5'h00, 200); `CHK("tgl_hold", 1'b1, sw_out)
        `CHK("tgl_once", c0 + 8'h01, on_cnt)
        press(5'h01, 6); `CHK("tgl_off", 1'b0, sw_out)
        press(5'h00, 6);
        // Timeouts: custom, tied high, tied to output
        bus_wr(8'h04, 32'd30);
        tmo_run(2'd1, 30);
        tmo_run(2'd2, 20);
        tmo_run(2'd3, 50);
        // Five pads: one pad at a time, outputs active low
        bus_wr(8'h00, 32'h02);
        for (int p = 0; p < 5; p++) begin
            press(5'h01 << p, 8);
            `CHK("key", ~(5'h01 << p), key_n)
            `CHK("pad_led", 5'h01 << p, pad_led)
            tv = (5'h01 << p) | (5'h01 << ((p + 1) % 5));
            press(tv, 8);
            `CHK("key_one", ~(5'h01 << p), key_n)
            `CHK("sw_five", 1'b0, sw_out)
            bus_rd(8'h08, d);
            `CHK("stat", {20'h0, tv, 1'b0, 5'h01 << p, 1'b0}, d)
            press(5'h00, 8);
            `CHK("key_rel", 5'h1f, key_n)
            `CHK("led_rel", 5'h00, pad_led)
        end
        // Spare variant code behaves as momentary
        bus_wr(8'h00, 32'h03);
        press(5'h01, 6); `CHK("alt_on", 1'b1, sw_out)
        press(5'h00, 6); `CHK("alt_off", 1'b0, sw_out)
        complete_run();
    end
endmodule // tb
